// ==== pkg/opc_defines.svh ====
/*
 * Timing counts and widths for the one-time-programmable ROM host controller.
 * Assumes a 50 MHz system clock; included by bare name.
 */
`ifndef OPC_DEFINES_SVH
`define OPC_DEFINES_SVH

// ****************************************************************
// Clock and pin timing
// ****************************************************************
`define OPC_CLK_MHZ 50
`define OPC_ACC_NS 90
`define OPC_ACC_CYC ((`OPC_ACC_NS * `OPC_CLK_MHZ + 999) / 1000)
`define OPC_SETUP_US 2
`define OPC_SETUP_CYC (`OPC_SETUP_US * `OPC_CLK_MHZ)
`define OPC_PULSE_US 50
`define OPC_PULSE_CYC (`OPC_PULSE_US * `OPC_CLK_MHZ)
`define OPC_FLOAT_NS 130
`define OPC_FLOAT_CYC ((`OPC_FLOAT_NS * `OPC_CLK_MHZ + 999) / 1000)
`define OPC_MAX_RETRY 10

// ****************************************************************
// Sizes
// ****************************************************************
`define OPC_WORD_AW 18
`define OPC_BYTE_AW 19
`define OPC_DW 16
`define OPC_ID_LINE 9

`endif

// ==== pkg/opc_pkg.sv ====
/*
 * Types for the ROM host controller.
 * Assumes nothing beyond the defines header.
 */
package opc_pkg;
    // Host commands
    typedef enum logic [2:0] {
        OPC_CMD_READ_WORD = 3'h0,
        OPC_CMD_READ_BYTE = 3'h1,
        OPC_CMD_READ_ID = 3'h2,
        OPC_CMD_PROGRAM = 3'h3,
        OPC_CMD_CHECK = 3'h4
    } opc_cmd_type;

    // Sequencer states
    typedef enum logic [3:0] {
        OPC_ST_IDLE = 4'h0,
        OPC_ST_SETUP = 4'h1,
        OPC_ST_ACCESS = 4'h2,
        OPC_ST_FLOAT = 4'h3,
        OPC_ST_PULSE = 4'h4,
        OPC_ST_HOLD = 4'h5,
        OPC_ST_VERIFY = 4'h6,
        OPC_ST_DONE = 4'h7
    } opc_state_type;
endpackage : opc_pkg

// ==== logic/opc_sync.sv ====
/*
 * Two-flop synchroniser bank for the data lanes coming back from the ROM.
 * Assumes the lanes are asynchronous to clock_i.
 */
`timescale 1ns/1ps
`default_nettype none
module opc_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule : opc_sync
`default_nettype wire

// ==== logic/opc_host.sv ====
/*
 * Host-side controller for a 4-Mbit one-time-programmable ROM: word, byte and
 * identification reads, and the programming pulse with verify and retries.
 * Assumes the board converts the level requests (program supply, id voltage)
 * into the real high voltages and joins the output enables to the ROM pins.
 */
// How it works
// - Word read: both controls low, width high
// - Program: supply high, enable high, pulse select
// - Id read: id voltage on line nine
// - Id read: others low, line zero picks
// - Supply tied to core outside programming
// - Every pulse of 50 us, verify after each
// - Up to ten retries, then fail
`timescale 1ns/1ps
`default_nettype none
`include "opc_defines.svh"
module opc_host #(
    parameter int ACC_CYC = `OPC_ACC_CYC,
    parameter int SETUP_CYC = `OPC_SETUP_CYC,
    parameter int PULSE_CYC = `OPC_PULSE_CYC,
    parameter int FLOAT_CYC = `OPC_FLOAT_CYC,
    parameter int MAX_RETRY = `OPC_MAX_RETRY
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire opc_pkg::opc_cmd_type cmd_i,
    input wire logic [`OPC_BYTE_AW-1:0] addr_i,
    input wire logic [`OPC_DW-1:0] wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic fail_o,
    output logic [`OPC_DW-1:0] rdata_o,
    output logic [`OPC_WORD_AW-1:0] rom_addr_o,
    output logic rom_cs_b_o,
    output logic rom_oe_b_o,
    output logic rom_width_o,
    output logic rom_vpp_o,
    output logic rom_id_hv_o,
    output logic [`OPC_DW-1:0] rom_data_o,
    output logic [`OPC_DW-1:0] rom_data_oe_b_o,
    input wire logic [`OPC_DW-1:0] rom_data_i
);
    // ************************************************************
    // State
    // ************************************************************
    opc_pkg::opc_state_type state;
    opc_pkg::opc_cmd_type cmd;
    logic [`OPC_BYTE_AW-1:0] addr;
    logic [`OPC_DW-1:0] wdata;
    logic [15:0] count;
    logic [3:0] retry;
    logic [`OPC_DW-1:0] lanes;

    opc_sync #(
        .WIDTH(`OPC_DW)
    ) u_sync (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .async_i(rom_data_i),
        .sync_o(lanes)
    );

    // Count loads for the access, float and verify phases; sync latency is added to each
    function automatic logic [15:0] phase_len(input int cyc);
        phase_len = 16'(cyc + 2);
    endfunction : phase_len

    function automatic logic is_prog(input opc_pkg::opc_cmd_type c);
        is_prog = (c == opc_pkg::OPC_CMD_PROGRAM) || (c == opc_pkg::OPC_CMD_CHECK);
    endfunction : is_prog

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Program keeps going until verify matches or retries run out
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= opc_pkg::OPC_ST_IDLE;
            cmd <= opc_pkg::OPC_CMD_READ_WORD;
            addr <= '0;
            wdata <= '0;
            count <= 16'h0000;
            retry <= 4'h0;
        end else begin
            case (state)
                opc_pkg::OPC_ST_IDLE: begin
                    if (req_i) begin
                        cmd <= cmd_i;
                        addr <= addr_i;
                        wdata <= wdata_i;
                        retry <= 4'h0;
                        count <= is_prog(cmd_i) ? 16'(SETUP_CYC) : phase_len(ACC_CYC);
                        state <= is_prog(cmd_i) ? opc_pkg::OPC_ST_SETUP : opc_pkg::OPC_ST_ACCESS;
                    end
                end
                opc_pkg::OPC_ST_SETUP: begin
                    // Supply, address and data settle before the pulse
                    if (count <= 16'h0001) begin
                        // Check skips the pulse, so it waits only the float time
                        count <= (cmd == opc_pkg::OPC_CMD_CHECK) ? phase_len(FLOAT_CYC) : 16'(PULSE_CYC);
                        state <= (cmd == opc_pkg::OPC_CMD_CHECK) ? opc_pkg::OPC_ST_FLOAT
                                                                  : opc_pkg::OPC_ST_PULSE;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
                opc_pkg::OPC_ST_PULSE: begin
                    if (count <= 16'h0001) begin
                        count <= 16'(SETUP_CYC);
                        state <= opc_pkg::OPC_ST_HOLD;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
                opc_pkg::OPC_ST_HOLD: begin
                    // Data hold after the pulse, then release the data lanes
                    if (count <= 16'h0001) begin
                        count <= phase_len(FLOAT_CYC);
                        state <= opc_pkg::OPC_ST_FLOAT;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
                opc_pkg::OPC_ST_FLOAT: begin
                    // Lanes floated, wait before enabling the ROM drive
                    if (count <= 16'h0001) begin
                        count <= phase_len(ACC_CYC + FLOAT_CYC);
                        state <= opc_pkg::OPC_ST_VERIFY;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
                opc_pkg::OPC_ST_VERIFY: begin
                    if (count <= 16'h0001) begin
                        if (lanes == wdata || cmd == opc_pkg::OPC_CMD_CHECK) begin
                            state <= opc_pkg::OPC_ST_DONE;
                        end else if (retry >= 4'(MAX_RETRY)) begin
                            state <= opc_pkg::OPC_ST_DONE;
                        end else begin
                            retry <= retry + 4'h1;
                            count <= 16'(SETUP_CYC);
                            state <= opc_pkg::OPC_ST_SETUP;
                        end
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
                opc_pkg::OPC_ST_ACCESS: begin
                    if (count <= 16'h0001) begin
                        state <= opc_pkg::OPC_ST_DONE;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
                opc_pkg::OPC_ST_DONE: begin
                    state <= opc_pkg::OPC_ST_IDLE;
                end
                default: begin
                    state <= opc_pkg::OPC_ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    // Controls come from flops; select and drive enable move separately
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rom_cs_b_o <= 1'b1;
            rom_oe_b_o <= 1'b1;
            rom_width_o <= 1'b1;
            rom_vpp_o <= 1'b0;
            rom_id_hv_o <= 1'b0;
            rom_addr_o <= '0;
        end else begin
            // Supply raised only while programming or checking
            rom_vpp_o <= is_prog(cmd) && state != opc_pkg::OPC_ST_IDLE && state != opc_pkg::OPC_ST_DONE;
            // Select low for reads and for the program pulse only
            rom_cs_b_o <= !(state == opc_pkg::OPC_ST_ACCESS || state == opc_pkg::OPC_ST_PULSE);
            // Drive enable low only for reads and verify
            rom_oe_b_o <= !(state == opc_pkg::OPC_ST_ACCESS || state == opc_pkg::OPC_ST_VERIFY);
            // Width low only for byte reads
            rom_width_o <= !(state == opc_pkg::OPC_ST_ACCESS && cmd == opc_pkg::OPC_CMD_READ_BYTE);
            rom_id_hv_o <= state == opc_pkg::OPC_ST_ACCESS && cmd == opc_pkg::OPC_CMD_READ_ID;
            if (state == opc_pkg::OPC_ST_ACCESS && cmd == opc_pkg::OPC_CMD_READ_ID) begin
                // Only line zero may be high, line nine set to id level
                rom_addr_o <= {{(`OPC_WORD_AW-1){1'b0}}, addr[0]};
            end else if (state == opc_pkg::OPC_ST_ACCESS && cmd == opc_pkg::OPC_CMD_READ_BYTE) begin
                rom_addr_o <= addr[`OPC_BYTE_AW-1:1];
            end else if (state != opc_pkg::OPC_ST_IDLE && state != opc_pkg::OPC_ST_DONE) begin
                rom_addr_o <= addr[`OPC_WORD_AW-1:0];
            end
        end
    end

    // Data lanes: host drives during program, top lane carries half-select in byte reads
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rom_data_o <= 16'h0000;
            rom_data_oe_b_o <= 16'hFFFF;
        end else begin
            rom_data_o <= 16'h0000;
            rom_data_oe_b_o <= 16'hFFFF;
            if (is_prog(cmd) && cmd == opc_pkg::OPC_CMD_PROGRAM &&
                (state == opc_pkg::OPC_ST_SETUP || state == opc_pkg::OPC_ST_PULSE ||
                 state == opc_pkg::OPC_ST_HOLD)) begin
                rom_data_o <= wdata;
                rom_data_oe_b_o <= 16'h0000;
            end else if (state == opc_pkg::OPC_ST_ACCESS && cmd == opc_pkg::OPC_CMD_READ_BYTE) begin
                rom_data_o <= {addr[0], 15'h0000};
                rom_data_oe_b_o <= 16'h7FFF;
            end
        end
    end

    // ************************************************************
    // Answer to the user side
    // ************************************************************
    // Byte reads keep the low eight lanes only: lanes eight to fourteen float, top lane carries half-select
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            fail_o <= 1'b0;
            rdata_o <= 16'h0000;
        end else begin
            busy_o <= state != opc_pkg::OPC_ST_IDLE || req_i;
            done_o <= state == opc_pkg::OPC_ST_DONE;
            if (state == opc_pkg::OPC_ST_ACCESS && count <= 16'h0001) begin
                rdata_o <= (cmd == opc_pkg::OPC_CMD_READ_BYTE) ? {8'h00, lanes[7:0]} : lanes;
                fail_o <= 1'b0;
            end else if (state == opc_pkg::OPC_ST_VERIFY && count <= 16'h0001) begin
                rdata_o <= lanes;
                fail_o <= lanes != wdata && (cmd == opc_pkg::OPC_CMD_CHECK || retry >= 4'(MAX_RETRY));
            end
        end
    end
endmodule : opc_host
`default_nettype wire

// ==== bench/opc_host_monitor.sv ====
/* Pin-level checker for the ROM host controller.
   Assumes a bind to opc_host, with its pulse and retry counts passed on. */
`timescale 1ns/1ps
`default_nettype none
module opc_host_monitor #(
    parameter int PULSE_CYC = 2500,
    parameter int MAX_RETRY = 10
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [17:0] rom_addr_o,
    input wire logic rom_cs_b_o,
    input wire logic rom_oe_b_o,
    input wire logic rom_width_o,
    input wire logic rom_vpp_o,
    input wire logic rom_id_hv_o,
    input wire logic [15:0] rom_data_oe_b_o
);
    // ****************************************
    // Helpers and properties
    // ****************************************
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    int low_cnt;
    int pulse_cnt;
    // Counters, since pulse width and retries exceed a short repetition
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_cnt <= 0;
            pulse_cnt <= 0;
        end else begin
            low_cnt <= (!rom_cs_b_o && rom_vpp_o) ? low_cnt + 1 : 0;
            if (!busy_o) pulse_cnt <= 0;
            else if (!rom_cs_b_o && rom_vpp_o && low_cnt == 0) pulse_cnt <= pulse_cnt + 1;
        end
    end
    sequence s_access;
        (!rom_cs_b_o && !rom_oe_b_o) [*5];
    endsequence
    a_idle_deselect: assert property (!busy_o |-> rom_cs_b_o && rom_oe_b_o) else $error("pins active while idle");
    a_no_contention: assert property (!rom_oe_b_o |-> rom_data_oe_b_o[14:0] == 15'h7FFF)
        else $error("host drives lanes while outputs enabled");
    a_half_select: assert property (!rom_oe_b_o && !rom_vpp_o |-> rom_data_oe_b_o[15] == rom_width_o)
        else $error("top lane direction does not follow width");
    a_program_pins: assert property (!rom_cs_b_o && rom_vpp_o |-> rom_oe_b_o && rom_data_oe_b_o == 16'h0000)
        else $error("program pulse without data or with drive enable");
    a_pulse_width: assert property ($rose(rom_cs_b_o) && rom_vpp_o |-> low_cnt == PULSE_CYC)
        else $error("program pulse length wrong");
    a_retry_limit: assert property (done_o |-> pulse_cnt <= MAX_RETRY + 1) else $error("too many pulses");
    a_read_hold: assert property ($fell(rom_oe_b_o) && !rom_vpp_o |-> s_access)
        else $error("read access cut short");
    a_id_inputs: assert property (rom_id_hv_o |-> rom_width_o && !rom_vpp_o && rom_addr_o[17:10] == 8'h00
        && rom_addr_o[8:1] == 8'h00) else $error("id read with other inputs high");
    a_done_pulse: assert property (done_o |=> !done_o && !busy_o) else $error("done not a single pulse");
endmodule : opc_host_monitor
`default_nettype wire

// ==== bench/opc_rom_model.sv ====
/* Behavioural model of the ROM on the far side of the lanes.
   Assumes the bench resolves lanes and feeds them back on lane_i. */
`timescale 1ns/1ps
`default_nettype none
module opc_rom_model #(
    parameter logic [15:0] MAKER_ID = 16'h3C3C, // Arbitrary value
    parameter logic [15:0] PART_ID = 16'h6969, // Arbitrary value
    parameter logic [7:0] STUCK = 8'h85
) (
    input wire logic [17:0] addr_i,
    input wire logic cs_b_i,
    input wire logic oe_b_i,
    input wire logic width_i,
    input wire logic vpp_i,
    input wire logic id_hv_i,
    input wire logic [15:0] lane_i,
    output logic [15:0] lane_o,
    output logic [15:0] drv_o,
    output logic [7:0] pulses_o
);
    // ****************************************
    // Storage and pins
    // ****************************************
    logic [15:0] mem [256]; // Only 256 words kept; upper address bits alias
    logic [15:0] word;
    // Upper half blank; the rest a pattern the bench also derives
    initial begin
        pulses_o = 8'h00;
        for (int a = 0; a < 256; a++) mem[a] = a[7] ? 16'hFFFF : {a[7:0] ^ 8'h5A, ~a[7:0]};
    end
    // Programming clears bits only; the stuck word ignores every pulse
    always @(posedge vpp_i) pulses_o = 8'h00;
    always @(posedge cs_b_i) begin
        if (vpp_i === 1'b1 && oe_b_i === 1'b1) begin
            pulses_o = pulses_o + 8'h01;
            if (addr_i[7:0] != STUCK) mem[addr_i[7:0]] = mem[addr_i[7:0]] & lane_i;
        end
    end
    // Output lanes; zero delay meets the access time
    always_comb begin
        word = mem[addr_i[7:0]];
        lane_o = 16'h0000;
        drv_o = 16'h0000;
        if (vpp_i) begin
            if (!oe_b_i) drv_o = 16'hFFFF;
            lane_o = word;
        end else if (!cs_b_i && !oe_b_i) begin
            if (id_hv_i) begin
                drv_o = 16'hFFFF;
                lane_o = addr_i[0] ? PART_ID : MAKER_ID;
            end else if (width_i) begin
                drv_o = 16'hFFFF;
                lane_o = word;
            end else begin
                drv_o = 16'h00FF;
                lane_o = {8'h00, lane_i[15] ? word[15:8] : word[7:0]};
            end
        end
    end
endmodule : opc_rom_model
`default_nettype wire

// ==== bench/opc_host_bench.sv ====
/* Self-checking bench for the ROM host controller with the ROM model.
   Assumes short pulse and retry counts; lanes float to a changing pattern. */
`timescale 1ns/1ps
`default_nettype none
module opc_host_bench;
    localparam int PC = 20;
    localparam int MR = 2;
    logic clock_i, rst_b_i, req_i, busy_o, done_o, fail_o, cs_b, oe_b, width, vpp, id_hv;
    opc_pkg::opc_cmd_type cmd_i;
    logic [18:0] addr_i;
    logic [17:0] rom_addr;
    logic [15:0] wdata_i, rdata_o, host_d, host_oe_b, rom_d, rom_drv, lanes;
    logic [15:0] float_pat = 16'h5A3C;
    logic [7:0] pulses;
    int checks, miscompares;
    opc_host #(.SETUP_CYC(4), .PULSE_CYC(PC), .MAX_RETRY(MR)) opc_host_i (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .req_i(req_i), .cmd_i(cmd_i), .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
        .fail_o(fail_o), .rdata_o(rdata_o), .rom_addr_o(rom_addr), .rom_cs_b_o(cs_b), .rom_oe_b_o(oe_b),
        .rom_width_o(width), .rom_vpp_o(vpp), .rom_id_hv_o(id_hv), .rom_data_o(host_d),
        .rom_data_oe_b_o(host_oe_b), .rom_data_i(lanes));
    opc_rom_model opc_rom_model_i (.addr_i(rom_addr), .cs_b_i(cs_b), .oe_b_i(oe_b), .width_i(width), .vpp_i(vpp),
        .id_hv_i(id_hv), .lane_i(lanes), .lane_o(rom_d), .drv_o(rom_drv), .pulses_o(pulses));
    // ****************************************
    // Clock, lanes and shared tasks
    // ****************************************
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    // Undriven lanes change every cycle so stale data cannot pass
    always @(posedge clock_i) float_pat <= ~float_pat;
    always_comb for (int i = 0; i < 16; i++) lanes[i] = !host_oe_b[i] ? host_d[i] : rom_drv[i] ? rom_d[i] : float_pat[i];
    function automatic logic [15:0] pat(input logic [7:0] a);
        return a[7] ? 16'hFFFF : {a ^ 8'h5A, ~a};
    endfunction : pat
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic run(input opc_pkg::opc_cmd_type c, input logic [18:0] a, input logic [15:0] d);
        int n;
        @(posedge clock_i);
        req_i <= 1'b1;
        cmd_i <= c;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        req_i <= 1'b0;
        for (n = 0; n < 2000 && done_o !== 1'b1; n++) @(negedge clock_i);
        if (n == 2000) begin
            miscompares++;
            close_out();
        end
    endtask : run
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_words();
        logic [17:0] al [3] = '{18'h00000, 18'h0007F, 18'h3FF2A};
        foreach (al[i]) begin
            run(opc_pkg::OPC_CMD_READ_WORD, {1'b0, al[i]}, 16'h0000);
            check(rdata_o, pat(al[i][7:0]));
        end
    endtask : t_words
    task automatic t_bytes();
        for (int h = 0; h < 2; h++) begin
            run(opc_pkg::OPC_CMD_READ_BYTE, {18'h00013, h[0]}, 16'h0000);
            check(rdata_o, h[0] ? pat(8'h13) >> 8 : pat(8'h13) & 16'h00FF);
        end
    endtask : t_bytes
    task automatic t_ident();
        for (int h = 0; h < 2; h++) begin
            run(opc_pkg::OPC_CMD_READ_ID, {18'h00000, h[0]}, 16'h0000);
            check(rdata_o, h[0] ? 16'h6969 : 16'h3C3C);
        end
    endtask : t_ident
    task automatic t_program();
        run(opc_pkg::OPC_CMD_PROGRAM, 19'h00090, 16'h1234);
        check({15'h0000, fail_o}, 16'h0000);
        check({8'h00, pulses}, 16'h0001);
        run(opc_pkg::OPC_CMD_READ_WORD, 19'h00090, 16'h0000);
        check(rdata_o, 16'h1234);
    endtask : t_program
    task automatic t_stuck();
        run(opc_pkg::OPC_CMD_PROGRAM, 19'h00085, 16'h4321);
        check({15'h0000, fail_o}, 16'h0001);
        check({8'h00, pulses}, 16'(MR + 1));
        check(rdata_o, 16'hFFFF);
    endtask : t_stuck
    task automatic t_verify();
        run(opc_pkg::OPC_CMD_CHECK, 19'h00091, 16'hFFFF);
        check({15'h0000, fail_o}, 16'h0000);
        check(rdata_o, 16'hFFFF);
        run(opc_pkg::OPC_CMD_CHECK, 19'h00091, 16'h0000);
        check({15'h0000, fail_o}, 16'h0001);
    endtask : t_verify
    // Main sequence
    initial begin
        {rst_b_i, req_i, checks, miscompares} = '0;
        cmd_i = opc_pkg::OPC_CMD_READ_WORD;
        addr_i = 19'h00000;
        wdata_i = 16'h0000;
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        t_words();
        t_bytes();
        t_ident();
        t_program();
        t_stuck();
        t_verify();
        close_out();
    end
endmodule : opc_host_bench
bind opc_host opc_host_monitor #(.PULSE_CYC(PULSE_CYC), .MAX_RETRY(MAX_RETRY)) opc_host_monitor_i (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .busy_o(busy_o), .done_o(done_o), .rom_addr_o(rom_addr_o),
    .rom_cs_b_o(rom_cs_b_o), .rom_oe_b_o(rom_oe_b_o), .rom_width_o(rom_width_o), .rom_vpp_o(rom_vpp_o),
    .rom_id_hv_o(rom_id_hv_o), .rom_data_oe_b_o(rom_data_oe_b_o));
`default_nettype wire
